// file: trace_capture_pkg.sv
package trace_capture_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_STATUS   = 12'h00c;
   localparam logic [11:0] OFS_RD_DATA  = 12'h010;
   localparam logic [11:0] OFS_RD_PTR   = 12'h014;
   localparam logic [11:0] OFS_WR_PTR   = 12'h018;
   localparam logic [11:0] OFS_TRG_CNT  = 12'h01c;
   localparam logic [11:0] OFS_CTL      = 12'h020;
   localparam logic [11:0] OFS_WR_DATA  = 12'h024;
   localparam logic [11:0] OFS_MODE     = 12'h028;
   localparam logic [11:0] OFS_PEAK     = 12'h02c;
   localparam logic [11:0] OFS_LIVE     = 12'h030;
   localparam logic [11:0] OFS_WMARK    = 12'h034;
   localparam logic [11:0] OFS_FFSTAT   = 12'h300;

   // Field positions
   localparam int CTL_CAPTURE_BIT  = 0;
   localparam int CTL_HALT_TRG_BIT = 1;
   localparam int MODE_HOLD_BIT    = 4;
   localparam int MEMORY_FULL_FLAG_BIT     = 0;
   localparam int STS_TRIG_BIT     = 1;
   localparam int STS_DRAINED_BIT  = 3;
   localparam int FFS_FLUSH_BIT    = 0;
   localparam int FFS_HALTED_BIT   = 1;
   localparam int TRG_CNT_W        = 30;
   localparam int LEVEL_MSB        = 30;
   localparam int WMARK_MSB        = 29;

   // Reset values and codes
   localparam logic [1:0]  MODE_CIRCULAR = 2'h0;
   localparam logic [1:0]  MODE_FIFO_ONE = 2'h1;
   localparam logic [6:0]  TRIGGER_ID    = 7'h7d;
   localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

   // Trigger sequencing states
   typedef enum logic [1:0] {
      TRG_IDLE  = 2'b00,
      TRG_COUNT = 2'b01,
      TRG_DONE  = 2'b10
   } trg_state_t;

endpackage

// file: trace_memory_capture_control.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - Circular: trigger edge or ID 0x7D, then count words, then event.
// - Control bit 0 enables capture, resets low; clearing it means Disabled.
// - Test data port writes memory only while disabled; ignored otherwise.
// - Wide words built from consecutive 32-bit writes; pointer steps once.
// - Mode 0 circular, 1 FIFO one; reserved codes act as FIFO one.
// - On halt, hold bit set drops ready; clear keeps ready and discards.
// - Peak read returns max words since last read, then reloads level.
// - Peak holds when disabled, ignores reads there; loads level on enable.
// - Both level registers have 1 + log2(depth) bits within 30:0.
// - Live level tracks when enabled, holds when disabled in FIFO modes, ignores pointers.
// - Circular mode while disabled: each read data access lowers a nonzero live level.
// - FIFO modes: full when level reaches depth minus watermark.
// - Watermark of depth minus 1 gives full after the first word.
// - Watermark reads back, log2(depth) bits within 29:0.
// - Circular mode: full asserts when the write pointer wraps.
// - Halted set when capture done with control bit 1 set; clears on enable, holds on disable.
// - Flush status follows flush activity while enabled; clears on enable.
module trace_memory_capture_control
   import trace_capture_pkg::*;
#(
   parameter int ENTRIES = 64,
   parameter int WPE     = 4
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // APB slave
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output      logic [31:0] prdata_o,
   output      logic        pready_o,
   output      logic        pslverr_o,
   // Trace input from sources
   input  wire logic        atvalid_i,
   input  wire logic [6:0]  atid_i,
   input  wire logic [31:0] atdata_i,
   output      logic        atready_o,
   // Trigger pin, flush activity, full
   input  wire logic        trigin_i,
   input  wire logic        flush_busy_i,
   output      logic        full_o
);

   localparam int DEPTH = ENTRIES * WPE;
   localparam int AW    = $clog2(DEPTH);
   localparam int EW    = $clog2(ENTRIES);
   localparam int SW    = $clog2(WPE);
   localparam int LW    = AW + 1;
   localparam int ENT_W = 32 * WPE;
   localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);

   // Zero-extend a level or watermark into a bus word
   function automatic logic [31:0] widen(input logic [LW-1:0] v);
      widen = {{(32-LW){1'b0}}, v};
   endfunction

   // Trace memory
   logic [ENT_W-1:0] mem [ENTRIES];

   // Registers
   logic                 cap_ff, halt_trg_ff, hold_ff;
   logic [1:0]           mode_ff;
   logic [TRG_CNT_W-1:0] trg_cnt_ff, trg_left_ff;
   logic [AW-1:0]        wmark_ff, rptr_ff;
   logic [EW-1:0]        wptr_ff;
   logic [ENT_W-1:0]     asm_ff;
   logic [SW-1:0]        asm_cnt_ff;
   logic [LW-1:0]        live_ff, peak_ff;
   logic                 full_ff, trig_ff, halted_ff, flush_ff;
   logic                 trg_sync1_ff, trg_sync2_ff, trg_prev_ff;
   logic [31:0]          prdata_ff;
   trg_state_t           trg_st_ff;

   // Next values
   logic [LW-1:0]        nxt_live, nxt_peak;
   logic                 nxt_full;
   trg_state_t           nxt_trg_st;
   logic [TRG_CNT_W-1:0] nxt_trg_left;

   // APB decode
   wire setup  = psel_i & ~penable_i;
   wire access = psel_i & penable_i;
   wire wr     = access & pwrite_i;
   wire rd     = access & ~pwrite_i;
   wire hit_sts   = paddr_i == OFS_STATUS;
   wire hit_rrd   = paddr_i == OFS_RD_DATA;
   wire hit_rptr  = paddr_i == OFS_RD_PTR;
   wire hit_wptr  = paddr_i == OFS_WR_PTR;
   wire hit_trg   = paddr_i == OFS_TRG_CNT;
   wire hit_ctl   = paddr_i == OFS_CTL;
   wire hit_wd    = paddr_i == OFS_WR_DATA;
   wire hit_mode  = paddr_i == OFS_MODE;
   wire hit_peak  = paddr_i == OFS_PEAK;
   wire hit_live  = paddr_i == OFS_LIVE;
   wire hit_wm    = paddr_i == OFS_WMARK;
   wire hit_ffs   = paddr_i == OFS_FFSTAT;
   wire hit_any   = hit_sts | hit_rrd | hit_rptr | hit_wptr | hit_trg
                  | hit_ctl | hit_wd | hit_mode | hit_peak | hit_live
                  | hit_wm | hit_ffs;
   wire ro_hit    = hit_sts | hit_rrd | hit_peak | hit_live | hit_ffs;
   wire bad_acc   = ~hit_any | (pwrite_i & ro_hit) | (~pwrite_i & hit_wd);

   // Leaving the Disabled state; entering it needs no action, flags and peak hold
   wire leave_dis = wr & hit_ctl & pwdata_i[CTL_CAPTURE_BIT] & ~cap_ff;

   // Effective mode, ignored while disabled
   wire eff_circ = cap_ff & (mode_ff == MODE_CIRCULAR);
   wire eff_fifo = cap_ff & (mode_ff != MODE_CIRCULAR);

   // Halt, ready and capture
   wire fifo_room = ~(eff_fifo & (live_ff == DEPTH_L));
   assign atready_o = ~(halted_ff & hold_ff) & fifo_room;
   wire take_beat = atvalid_i & atready_o & cap_ff;
   wire cap_word  = take_beat & ~halted_ff;
   wire test_word = wr & hit_wd & ~cap_ff;
   wire put_word  = cap_word | test_word;
   wire [31:0] put_data = cap_ff ? atdata_i : pwdata_i;
   wire last_slot = asm_cnt_ff == SW'(WPE - 1);
   wire ent_write = put_word & last_slot;
   wire wrap_ev   = ent_write & cap_ff & (wptr_ff == EW'(ENTRIES - 1));

   // Trigger sources
   wire trg_edge  = trg_sync2_ff & ~trg_prev_ff;
   wire trg_pkt   = take_beat & (atid_i == TRIGGER_ID);
   wire trg_arm   = eff_circ & (trg_edge | trg_pkt);

   // Read-data access and level arithmetic
   wire rrd_rd   = rd & hit_rrd;
   wire live_nz  = live_ff != '0;
   wire [LW-1:0] wm_l     = {1'b0, wmark_ff};
   wire [LW-1:0] fifo_lim = DEPTH_L - wm_l;
   wire          fifo_hit = live_ff >= fifo_lim;

   // Read data word from memory
   wire [EW-1:0]    rd_ent  = rptr_ff[AW-1:SW];
   wire [SW-1:0]    rd_sel  = rptr_ff[SW-1:0];
   wire [ENT_W-1:0] rd_line = mem[rd_ent];
   wire [31:0]      rd_word = rd_line[32*rd_sel +: 32];

   // Trigger sequencing
   always_comb begin
      nxt_trg_st   = trg_st_ff;
      nxt_trg_left = trg_left_ff;
      case (trg_st_ff)
         TRG_IDLE: begin
            if (trg_arm) begin
               nxt_trg_left = trg_cnt_ff;
               nxt_trg_st   = TRG_COUNT;
            end
         end
         TRG_COUNT: begin
            if (trg_left_ff == '0) begin
               nxt_trg_st = TRG_DONE;
            end else if (cap_word) begin
               nxt_trg_left = trg_left_ff - 1'b1;
            end
         end
         TRG_DONE: begin
            nxt_trg_st = TRG_DONE;
         end
         default: begin
            nxt_trg_st = TRG_IDLE;
         end
      endcase
      if (leave_dis || !cap_ff) begin
         nxt_trg_st = TRG_IDLE;
      end
   end

   wire trg_event = (trg_st_ff == TRG_COUNT) && (trg_left_ff == '0)
                  && cap_ff;

   // Live occupancy
   always_comb begin
      nxt_live = live_ff;
      if (leave_dis) begin
         nxt_live = '0;
      end else if (cap_ff) begin
         if (cap_word && !(eff_fifo && rrd_rd && live_nz)) begin
            if (!(eff_circ && live_ff == DEPTH_L)) begin
               nxt_live = live_ff + 1'b1;
            end
         end else if (!cap_word && eff_fifo && rrd_rd && live_nz) begin
            nxt_live = live_ff - 1'b1;
         end
      end else if (rrd_rd && mode_ff == MODE_CIRCULAR && live_nz) begin
         nxt_live = live_ff - 1'b1;
      end
   end

   // Peak occupancy
   always_comb begin
      nxt_peak = peak_ff;
      if (leave_dis) begin
         nxt_peak = nxt_live;
      end else if (cap_ff && rd && hit_peak) begin
         nxt_peak = live_ff;
      end else if (cap_ff && live_ff > peak_ff) begin
         nxt_peak = live_ff;
      end
   end

   // Full flag
   always_comb begin
      nxt_full = full_ff;
      if (leave_dis) begin
         nxt_full = 1'b0;
      end else if (eff_fifo) begin
         nxt_full = fifo_hit;
      end else if (eff_circ && wrap_ev) begin
         nxt_full = 1'b1;
      end
   end

   assign full_o = full_ff;

   // Read mux, sampled in the setup phase
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = RESET_WORD;
      if (hit_sts) begin
         rd_mux[MEMORY_FULL_FLAG_BIT]    = full_ff;
         rd_mux[STS_TRIG_BIT]    = trig_ff;
         rd_mux[STS_DRAINED_BIT] = halted_ff;
      end else if (hit_rrd) begin
         rd_mux = rd_word;
      end else if (hit_rptr) begin
         rd_mux = {{(32-AW){1'b0}}, rptr_ff};
      end else if (hit_wptr) begin
         rd_mux = {{(32-EW){1'b0}}, wptr_ff};
      end else if (hit_trg) begin
         rd_mux = {2'b00, trg_cnt_ff};
      end else if (hit_ctl) begin
         rd_mux[CTL_CAPTURE_BIT]  = cap_ff;
         rd_mux[CTL_HALT_TRG_BIT] = halt_trg_ff;
      end else if (hit_mode) begin
         rd_mux[1:0]           = mode_ff;
         rd_mux[MODE_HOLD_BIT] = hold_ff;
      end else if (hit_peak) begin
         rd_mux = widen(peak_ff);
      end else if (hit_live) begin
         rd_mux = widen(live_ff);
      end else if (hit_wm) begin
         rd_mux = widen(wm_l);
      end else if (hit_ffs) begin
         rd_mux[FFS_FLUSH_BIT]  = flush_ff;
         rd_mux[FFS_HALTED_BIT] = halted_ff;
      end
   end

   assign pready_o  = 1'b1;
   assign pslverr_o = access & bad_acc;
   assign prdata_o  = prdata_ff;

   // Trigger pin synchroniser
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         trg_sync1_ff <= 1'b0;
         trg_sync2_ff <= 1'b0;
         trg_prev_ff  <= 1'b0;
      end else begin
         trg_sync1_ff <= trigin_i;
         trg_sync2_ff <= trg_sync1_ff;
         trg_prev_ff  <= trg_sync2_ff;
      end
   end

   // Software-written control registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cap_ff      <= 1'b0;
         halt_trg_ff <= 1'b0;
         mode_ff     <= MODE_CIRCULAR;
         hold_ff     <= 1'b0;
         trg_cnt_ff  <= '0;
         wmark_ff    <= '0;
      end else if (wr) begin
         if (hit_ctl) begin
            cap_ff      <= pwdata_i[CTL_CAPTURE_BIT];
            halt_trg_ff <= pwdata_i[CTL_HALT_TRG_BIT];
         end
         if (hit_mode) begin
            mode_ff <= pwdata_i[1:0];
            hold_ff <= pwdata_i[MODE_HOLD_BIT];
         end
         if (hit_trg) begin
            trg_cnt_ff <= pwdata_i[TRG_CNT_W-1:0];
         end
         if (hit_wm) begin
            wmark_ff <= pwdata_i[AW-1:0];
         end
      end
   end

   // Pointers, assembly and memory write
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wptr_ff    <= '0;
         rptr_ff    <= '0;
         asm_ff     <= '0;
         asm_cnt_ff <= '0;
      end else begin
         if (wr && hit_wptr && !cap_ff) begin
            wptr_ff    <= pwdata_i[EW-1:0];
            asm_cnt_ff <= '0;
         end else if (put_word) begin
            asm_ff[32*asm_cnt_ff +: 32] <= put_data;
            asm_cnt_ff <= last_slot ? '0 : asm_cnt_ff + 1'b1;
            if (ent_write) begin
               wptr_ff <= wptr_ff + 1'b1;
            end
         end
         if (wr && hit_rptr && !cap_ff) begin
            rptr_ff <= pwdata_i[AW-1:0];
         end else if (rrd_rd) begin
            rptr_ff <= rptr_ff + 1'b1;
         end
      end
   end

   // Trace memory has no reset
   always_ff @(posedge clock_i) begin
      if (ent_write) begin
         mem[wptr_ff] <= {put_data, asm_ff[ENT_W-33:0]};
      end
   end

   // Levels, flags, trigger state, read data
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         live_ff     <= '0;
         peak_ff     <= '0;
         full_ff     <= 1'b0;
         trig_ff     <= 1'b0;
         halted_ff   <= 1'b0;
         flush_ff    <= 1'b0;
         trg_st_ff   <= TRG_IDLE;
         trg_left_ff <= '0;
         prdata_ff   <= RESET_WORD;
      end else begin
         live_ff     <= nxt_live;
         peak_ff     <= nxt_peak;
         full_ff     <= nxt_full;
         trg_st_ff   <= nxt_trg_st;
         trg_left_ff <= nxt_trg_left;
         if (leave_dis) begin
            trig_ff   <= 1'b0;
            halted_ff <= 1'b0;
            flush_ff  <= 1'b0;
         end else if (cap_ff) begin
            flush_ff <= flush_busy_i;
            if (trg_event) begin
               trig_ff <= 1'b1;
               if (halt_trg_ff) begin
                  halted_ff <= 1'b1;
               end
            end
         end
         if (setup) begin
            prdata_ff <= pwrite_i ? RESET_WORD : rd_mux;
         end
      end
   end

endmodule // trace_memory_capture_control

// file: capture_props.sv
`timescale 1ns/1ps

module capture_props
   import trace_capture_pkg::*;
(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   // APB slave side
   input wire logic [11:0] paddr_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   // Trace ready and full
   input wire logic        atready_o,
   input wire logic        full_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // Access phase decode and capture enable edge
   logic cap_ff;
   wire  acc   = psel_i && penable_i;
   wire  wr_en = acc && pwrite_i && paddr_i == OFS_CTL && !pslverr_o;
   wire  go_en = wr_en && pwdata_i[CTL_CAPTURE_BIT] && !cap_ff;

   // Mirror of the capture enable as software writes it
   always_ff @(posedge clock_i) begin
      if (!rst_n_i)
         cap_ff <= 1'b0;
      else if (wr_en)
         cap_ff <= pwdata_i[CTL_CAPTURE_BIT];
   end

   // One access phase to a given address
   sequence s_acc(logic [11:0] a);
      acc && paddr_i == a;
   endsequence

   a_reset_idle: assert property (disable iff (1'b0)
      !rst_n_i |=> !full_o && atready_o) else $error("reset outputs wrong");
   a_full_clear: assert property (go_en |-> ##2 !full_o)
      else $error("full not cleared on enable");
   a_ready_open: assert property (go_en |=> atready_o [*2])
      else $error("sources stalled after enable");
   a_level_ro: assert property ((s_acc(OFS_PEAK) or s_acc(OFS_LIVE))
      ##0 pwrite_i |-> pslverr_o) else $error("level write accepted");
   a_status_ro: assert property (s_acc(OFS_FFSTAT) ##0 pwrite_i
      |-> pslverr_o) else $error("status write accepted");
   a_port_read: assert property (s_acc(OFS_WR_DATA) ##0 !pwrite_i
      |-> pslverr_o) else $error("data port read accepted");
   a_port_write: assert property (s_acc(OFS_WR_DATA) ##0 pwrite_i
      && !cap_ff |-> !pslverr_o) else $error("data port write refused");
   a_rdata_stand: assert property (acc && !pwrite_i
      |=> $stable(prdata_o)) else $error("read data moved after access");
endmodule // capture_props

bind trace_memory_capture_control capture_props u_props (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .atready_o(atready_o), .full_o(full_o));

// file: atb_source_model.sv
`timescale 1ns/1ps

module atb_source_model (
   // Clock
   input  wire logic        clock_i,
   // Beat toward the sink
   input  wire logic        atready_i,
   output      logic        atvalid_o,
   output      logic [6:0]  atid_o,
   output      logic [31:0] atdata_o
);
   // Idle until the first beat
   initial begin
      atvalid_o = 1'b0;
      atid_o    = 7'h00;
      atdata_o  = 32'h0;
   end

   // Hold a beat until taken; released lines show the inverse value
   task automatic send(input logic [6:0] id, input logic [31:0] d,
                       input int gap);
      atvalid_o <= 1'b1;
      atid_o    <= id;
      atdata_o  <= d;
      do @(posedge clock_i); while (atready_i !== 1'b1);
      if (gap > 0) begin
         atvalid_o <= 1'b0;
         atid_o    <= ~id;
         atdata_o  <= ~d;
         repeat (gap) @(posedge clock_i);
      end
   endtask
endmodule // atb_source_model

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top
   import trace_capture_pkg::*;
;
   localparam int E = 64;
   localparam int W = 4;
   localparam int D = E * W;
   // Design inputs
   logic        clock_i      = 1'b0;
   logic        rst_n_i      = 1'b0;
   logic        psel_i       = 1'b0;
   logic        penable_i    = 1'b0;
   logic        pwrite_i     = 1'b0;
   logic [11:0] paddr_i      = 12'h000;
   logic [31:0] pwdata_i     = 32'h0;
   logic        trigin_i     = 1'b0;
   logic        flush_busy_i = 1'b0;
   // Design outputs and source lines
   logic [31:0] prdata_o, atdata_i, rv;
   logic [6:0]  atid_i;
   logic        pready_o, pslverr_o, atready_o, full_o, atvalid_i, ev;
   int          err_count = 0;
   int          checks    = 0;
   int          cyc       = 0;

   always #2 clock_i = ~clock_i;

   trace_memory_capture_control #(.ENTRIES(E), .WPE(W)) u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .atvalid_i(atvalid_i), .atid_i(atid_i),
      .atdata_i(atdata_i), .atready_o(atready_o), .trigin_i(trigin_i),
      .flush_busy_i(flush_busy_i), .full_o(full_o));
   atb_source_model u_src (
      .clock_i(clock_i), .atready_i(atready_o), .atvalid_o(atvalid_i),
      .atid_o(atid_i), .atdata_o(atdata_i));

   // Report, verdict and stop
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask

   // One APB transfer, then one idle cycle
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel_i    <= 1'b1;
      paddr_i   <= a;
      pwrite_i  <= w;
      pwdata_i  <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, rv, ev);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input string n);
      apb(a, 1'b0, 32'h0, rv, ev);
      chk(n, exp, rv);
   endtask

   task automatic t_regs();
      logic [11:0] ro [3] = '{OFS_PEAK, OFS_LIVE, OFS_FFSTAT};
      int i;
      rd(OFS_CTL, 32'h0, "control reset");
      rd(OFS_FFSTAT, 32'h0, "status reset");
      chk("pready idle", 32'h1, 32'(pready_o));
      apb(12'h040, 1'b0, 32'h0, rv, ev);
      chk("unmapped error", 32'h1, 32'(ev));
      apb(OFS_WR_DATA, 1'b0, 32'h0, rv, ev);
      chk("port read error", 32'h1, 32'(ev));
      for (i = 0; i < 3; i++) begin
         apb(ro[i], 1'b1, 32'h1, rv, ev);
         chk("read-only error", 32'h1, 32'(ev));
      end
      for (i = 0; i < 4; i++) begin
         wr(OFS_MODE, 32'h10 | 32'(i));
         rd(OFS_MODE, 32'h10 | 32'(i), "mode code");
      end
      wr(OFS_WMARK, 32'hffff_ffff);
      rd(OFS_WMARK, 32'(D - 1), "watermark width");
   endtask

   // Reserved mode acts as FIFO; watermark of depth minus one
   task automatic t_fifo();
      wr(OFS_MODE, 32'h2);
      wr(OFS_CTL, 32'h1);
      chk("full idle", 32'h0, 32'(full_o));
      u_src.send(7'h01, 32'h1111_0000, 1);
      repeat (3) @(posedge clock_i);
      chk("full first word", 32'h1, 32'(full_o));
      u_src.send(7'h01, 32'h1111_0001, 0);
      u_src.send(7'h01, 32'h1111_0002, 2);
      rd(OFS_PEAK, 32'h3, "peak three");
      apb(OFS_RD_DATA, 1'b0, 32'h0, rv, ev);
      rd(OFS_LIVE, 32'h2, "live after read");
      rd(OFS_PEAK, 32'h3, "peak max");
      rd(OFS_PEAK, 32'h2, "peak reload");
      // Drop live under peak so a wrong reload while disabled shows
      apb(OFS_RD_DATA, 1'b0, 32'h0, rv, ev);
      wr(OFS_CTL, 32'h0);
      u_src.send(7'h01, 32'h2222_0000, 1);
      wr(OFS_WR_PTR, 32'h0);
      rd(OFS_LIVE, 32'h1, "live held");
      rd(OFS_PEAK, 32'h2, "peak held");
      rd(OFS_PEAK, 32'h2, "peak unread");
   endtask

   // Circular capture: trigger by packet or pin, halt on trigger
   task automatic t_trig(input logic pin, input logic hold);
      int i;
      wr(OFS_MODE, {27'h0, hold, 4'h0});
      wr(OFS_TRG_CNT, 32'h4);
      wr(OFS_WR_PTR, pin ? 32'(E - 1) : 32'h0);
      wr(OFS_CTL, 32'h3);
      rd(OFS_PEAK, 32'h0, "peak on enable");
      rd(OFS_FFSTAT, 32'h0, "halt cleared");
      if (pin) begin
         trigin_i <= 1'b1;
         repeat (5) @(posedge clock_i);
         trigin_i <= 1'b0;
      end else
         u_src.send(TRIGGER_ID, 32'h7d7d_0000, 1);
      for (i = 0; i < 4; i++)
         u_src.send(7'h02, 32'(i), int'(i == 3));
      repeat (4) @(posedge clock_i);
      apb(OFS_STATUS, 1'b0, 32'h0, rv, ev);
      chk("triggered", 32'h1, 32'(rv[STS_TRIG_BIT]));
      chk("ready on halt", 32'(!hold), 32'(atready_o));
      chk("wrap full", 32'(pin), 32'(full_o));
      rd(OFS_FFSTAT, 32'h2, "halted set");
      if (!hold) begin
         u_src.send(7'h02, 32'h5, 1);
         rd(OFS_LIVE, 32'h4, "discarded beat");
      end
      wr(OFS_CTL, 32'h0);
      rd(OFS_FFSTAT, 32'h2, "halted kept");
      if (!hold) begin
         apb(OFS_RD_DATA, 1'b0, 32'h0, rv, ev);
         rd(OFS_LIVE, 32'h3, "level after read");
      end
   endtask

   task automatic t_flush();
      wr(OFS_CTL, 32'h1);
      flush_busy_i <= 1'b1;
      @(posedge clock_i);
      rd(OFS_FFSTAT, 32'h1, "flush active");
      wr(OFS_CTL, 32'h0);
      flush_busy_i <= 1'b0;
      rd(OFS_FFSTAT, 32'h1, "flush frozen");
      wr(OFS_CTL, 32'h1);
      rd(OFS_FFSTAT, 32'h0, "flush cleared");
      wr(OFS_CTL, 32'h0);
   endtask

   // Port write while enabled must not complete the entry
   task automatic t_wdata();
      int i;
      wr(OFS_WR_PTR, 32'h5);
      for (i = 0; i < 3; i++)
         wr(OFS_WR_DATA, 32'hc0de_0000 + 32'(i));
      wr(OFS_CTL, 32'h1);
      wr(OFS_WR_DATA, 32'hbad0_0000);
      wr(OFS_CTL, 32'h0);
      wr(OFS_WR_DATA, 32'hc0de_0003);
      rd(OFS_WR_PTR, 32'h6, "pointer step");
      wr(OFS_RD_PTR, 32'(5 * W));
      for (i = 0; i < 4; i++)
         rd(OFS_RD_DATA, 32'hc0de_0000 + 32'(i), "memory word");
   endtask

   // Cut a hang short
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      t_regs();
      t_fifo();
      t_trig(1'b0, 1'b1);
      t_trig(1'b1, 1'b0);
      t_flush();
      t_wdata();
      end_sim();
   end
endmodule // tb_top
